// *** hdl/flc_pkg.sv ***
package flc_pkg;
  // Command codes written on the flash data bus.
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  // Field positions of write_machine_status.
  localparam int SR_READY     = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_SUPPLY    = 3;
  localparam int SR_WRITE_SUSP = 2;
  localparam int SR_PROTECT   = 1;
  localparam logic [7:0] SR_ERROR_MASK = 8'h3A;
  localparam logic [7:0] SR_VALID_MASK = 8'hFE;
  // Bus timing in ns and derived cycles at 25 MHz.
  localparam int CLK_NS        = 40;
  localparam int WE_LOW_NS     = 100;
  localparam int WE_HIGH_NS    = 100;
  localparam int OE_ACCESS_NS  = 150;
  localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_ACCESS_CYC = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W       = 4;
  // Operations the user may order.
  typedef enum logic [2:0] {
    FLC_OP_SET_BLOCK  = 3'b000,
    FLC_OP_SET_MASTER = 3'b001,
    FLC_OP_CLEAR_LOCKS = 3'b010,
    FLC_OP_ERASE      = 3'b011,
    FLC_OP_CLEAR_STATUS = 3'b100,
    FLC_OP_READ_ARRAY = 3'b101
  } flc_op_type;
endpackage : flc_pkg

// *** hdl/flc_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for pins arriving from the flash.
module flc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // System clock.
  input  wire logic         srst, // Synchronous reset.
  input  wire logic [W-1:0] d,    // Asynchronous input.
  output logic      [W-1:0] q     // Synchronised output.
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : flc_sync

// *** hdl/flc_host.sv ***
`timescale 1ns/1ps
// Contract
// RQ1: Block flags gate writes; master gates flags.
// RQ2: Master set needs override pin for block.
// RQ3: Lock set is setup then confirm write.
// RQ4: Status reads follow; poll ready pin/bit.
// RQ5: Status mode persists until next command.
// RQ6: Bad lock-set pairing sets bits 4,5.
// RQ7: Block set refused under master without override.
// RQ8: Master set needs override level.
// RQ9: Clear-locks clears all; override if master.
// RQ10: Bad clear sequence sets bits 4,5.
// RQ11: Low supply clear sets bits 3,5.
// RQ12: Clear under master without override: bits 1,5.
// RQ13: Aborted clear must be repeated by host.
// RQ14: Master flag can never be cleared.
// RQ15: Locked block writable only with override.
// RQ16: Bits 7,6,2 show ready and suspends.
// RQ17: Bits 5,4,3,1 errors; bit 0 reserved.
// RQ18: Ignore bits 6..0 while bit 7 low.
// RQ19: Supply flag sampled only after sequences.
// RQ20: Protect flag sampled only after sequences.
// RQ21: Host masks reserved status bit 0.
// RQ22: Erase is 20H,D0H, poll, then FFH; the controller ends after the poll, FFH is a separate read-array order.
// RQ23: Lock codes 60H then 01H or F1H.
// RQ24: Clear-locks is 60H then D0H.
// RQ25: Error bits stay until 50H written.
// RQ26: Busy pin low exactly while bit 7 low.
module flc_host
  import flc_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  input  wire logic              clk,          // 25 MHz system clock.
  input  wire logic              srst,         // Synchronous reset, active high.
  input  wire logic              cmd_valid,    // User requests an operation.
  output logic                   cmd_ready,    // Controller is idle and takes the request.
  input  wire flc_pkg::flc_op_type cmd_op,     // Operation to perform.
  input  wire logic [ADDR_W-1:0] cmd_addr,     // Block or device address.
  input  wire logic              cmd_override, // Raise the reset pin to override level.
  output logic                   done,         // One-cycle pulse at operation end.
  output logic [7:0]             done_status,  // Final status, bit 0 masked.
  output logic                   done_error,   // Any error flag set in final status.
  output logic [ADDR_W-1:0]      fl_addr,      // Flash address pins.
  output logic [7:0]             fl_dq_o,      // Flash data driven out.
  output logic                   fl_dq_oe,     // High while driving the data pins.
  input  wire logic [7:0]        fl_dq_i,      // Flash data read back.
  output logic                   fl_ce_n,      // Chip enable, active low.
  output logic                   fl_we_n,      // Write enable, active low.
  output logic                   fl_oe_n,      // Output enable, active low.
  output logic                   fl_rp_n,      // Reset pin released (high) when 1.
  output logic                   fl_rp_override, // Drive override level on reset pin.
  input  wire logic              ready_busy_output // Flash ready pin, low while busy.
);
  import flc_pkg::*;

  // Sequencer states: two write strobes, then a wait for ready and a status read.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_W1_LOW = 4'b0001,
    ST_W1_HI  = 4'b0010,
    ST_W2_LOW = 4'b0011,
    ST_W2_HI  = 4'b0100,
    ST_WAIT   = 4'b0101,
    ST_READ   = 4'b0110,
    ST_DONE   = 4'b0111
  } flc_state_type;

  // Request copy held for the whole order, plus the status that is reported.
  flc_state_type     state_reg, state_next;
  logic [TIMER_W-1:0] timer_reg;
  flc_op_type        op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              ovr_reg;
  logic [7:0]        status_reg;
  logic              done_reg;
  logic              two_cycle_reg;
  logic              rb_sync;
  logic [7:0]        dq_sync;
  logic              clr_phase_reg; // Next first write is a status clear before a repeat.
  logic              retried_reg;   // The current order has already been repeated once.

  // Both pins come from the flash with no clock relation to ours.
  flc_sync #(.W(1)) u_rb_sync (
    .clk  (clk),
    .srst (srst),
    .d    (ready_busy_output),
    .q    (rb_sync)
  );
  flc_sync #(.W(8)) u_dq_sync (
    .clk  (clk),
    .srst (srst),
    .d    (fl_dq_i),
    .q    (dq_sync)
  );

  // First and second command bytes per operation.
  wire [7:0] first_code =
      clr_phase_reg                   ? CMD_CLEAR_STATUS : // see RQ13
      (op_reg == FLC_OP_ERASE)        ? CMD_ERASE_SETUP :  // see RQ22
      (op_reg == FLC_OP_CLEAR_STATUS) ? CMD_CLEAR_STATUS : // see RQ25
      (op_reg == FLC_OP_READ_ARRAY)   ? CMD_READ_ARRAY :
      CMD_LOCK_SETUP;                                       // see RQ3 see RQ23 see RQ24
  wire [7:0] second_code =
      (op_reg == FLC_OP_SET_BLOCK)  ? CMD_BLOCK_CONFIRM :  // see RQ23
      (op_reg == FLC_OP_SET_MASTER) ? CMD_MASTER_CONFIRM : // see RQ23
      (op_reg == FLC_OP_ERASE)      ? CMD_ERASE_CONFIRM :  // see RQ22
      CMD_CLEAR_CONFIRM;                                    // see RQ24
  wire two_cycle = (cmd_op != FLC_OP_CLEAR_STATUS) && (cmd_op != FLC_OP_READ_ARRAY);
  wire in_second = (state_reg == ST_W2_LOW) || (state_reg == ST_W2_HI);
  wire timer_zero = (timer_reg == '0);
  // Masking bit 0 keeps a future reserved value from faking an error.
  wire [7:0] masked_status = dq_sync & SR_VALID_MASK; // see RQ21
  wire       status_final  = (state_reg == ST_READ) && timer_zero && dq_sync[SR_READY];

  // A clear-locks cut short by a supply abort leaves the block flags undetermined,
  // so the controller clears status and repeats the whole order once by itself.
  // Only one repeat is made: while the supply stays low a second try aborts as well,
  // and that result is then reported to the user.
  wire clear_aborted = (op_reg == FLC_OP_CLEAR_LOCKS) && masked_status[SR_SUPPLY]; // see RQ13
  wire retry_now     = status_final && clear_aborted && !retried_reg; // see RQ13

  // Pins follow the state; writes latch on the rising edge of write enable.
  assign cmd_ready   = (state_reg == ST_IDLE);
  assign fl_addr     = addr_reg;
  assign fl_dq_o     = in_second ? second_code : first_code;
  assign fl_dq_oe    = (state_reg != ST_IDLE) && (state_reg != ST_WAIT) &&
                       (state_reg != ST_READ) && (state_reg != ST_DONE);
  assign fl_we_n     = !((state_reg == ST_W1_LOW) || (state_reg == ST_W2_LOW));
  assign fl_oe_n     = (state_reg != ST_READ);
  assign fl_ce_n     = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
  assign fl_rp_n     = 1'b1;
  assign fl_rp_override = ovr_reg; // see RQ2 see RQ8 see RQ9 see RQ15
  assign done        = done_reg;
  assign done_status = status_reg;
  assign done_error  = |(status_reg & SR_ERROR_MASK); // see RQ17

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   if (cmd_valid) state_next = ST_W1_LOW;
      ST_W1_LOW: if (timer_zero) state_next = ST_W1_HI;
      ST_W1_HI: begin
        // A repeat's status clear is followed by a fresh setup write.
        if (timer_zero) begin
          if (clr_phase_reg) begin
            state_next = ST_W1_LOW;
          end else begin
            state_next = two_cycle_reg ? ST_W2_LOW : ST_DONE;
          end
        end
      end
      ST_W2_LOW: if (timer_zero) state_next = ST_W2_HI;
      ST_W2_HI:  if (timer_zero) state_next = ST_WAIT;
      // The busy pin only goes low after the confirm, so status is read once it rises.
      ST_WAIT:   if (timer_zero && rb_sync) state_next = ST_READ; // see RQ4 see RQ26
      ST_READ: begin
        // Bits 6..0 are only trusted once bit 7 reads ready.
        if (retry_now) begin
          state_next = ST_W1_LOW; // see RQ13
        end else if (status_final) begin
          state_next = ST_DONE; // see RQ18 see RQ5
        end
      end
      ST_DONE:   state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  // Timer reload on each state change.
  // The extra two cycles cover the synchroniser delay before a pin is trusted.
  wire [TIMER_W-1:0] timer_load =
      (state_next == ST_W1_LOW || state_next == ST_W2_LOW) ? TIMER_W'(WE_LOW_CYC) :
      (state_next == ST_READ) ? TIMER_W'(OE_ACCESS_CYC + 2) :
      TIMER_W'(WE_HIGH_CYC + 2);

  // State, timer and request capture.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= '0;
      op_reg        <= FLC_OP_READ_ARRAY;
      addr_reg      <= '0;
      ovr_reg       <= 1'b0;
      two_cycle_reg <= 1'b0;
      clr_phase_reg <= 1'b0;
      retried_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        timer_reg <= timer_load;
      end else if (!timer_zero) begin
        timer_reg <= timer_reg - 1'b1;
      end
      if (state_reg == ST_IDLE && cmd_valid) begin
        op_reg        <= cmd_op;
        addr_reg      <= cmd_addr; // see RQ3
        ovr_reg       <= cmd_override;
        two_cycle_reg <= two_cycle;
      end else if (state_next == ST_IDLE) begin
        ovr_reg <= 1'b0;
      end
      // The repeat flag lives for one order; the clear phase ends with its own write.
      if (retry_now) begin
        clr_phase_reg <= 1'b1;
        retried_reg   <= 1'b1;
      end else if (state_reg == ST_W1_HI && timer_zero) begin
        clr_phase_reg <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
        retried_reg   <= 1'b0;
      end
    end
  end

  // Final status and completion pulse.
  // A one-write order reports a zero status, since the flash never becomes busy.
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= (state_next == ST_DONE);
      if (state_reg == ST_READ && state_next == ST_DONE) begin
        status_reg <= masked_status; // see RQ6 see RQ7 see RQ10 see RQ11 see RQ12
      end else if (state_reg == ST_W1_HI && state_next == ST_DONE) begin
        status_reg <= '0;
      end
    end
  end
endmodule : flc_host

// *** sim/flc_flash_model.sv ***
`timescale 1ns/1ps
// Flash stand-in; reads always give status, as the controller only ever polls status.
module flc_flash_model #(parameter int BUSY = 20) (
  input  wire logic        clk,               // Paces busy time.
  input  wire logic [20:0] fl_addr,           // Address.
  input  wire logic [7:0]  fl_dq_o,           // Data in.
  input  wire logic        fl_ce_n,           // Chip enable.
  input  wire logic        fl_we_n,           // Write strobe.
  input  wire logic        fl_oe_n,           // Read strobe.
  input  wire logic        fl_rp_override,    // Override level.
  input  wire logic        vpp_lo,            // Supply low.
  output logic      [7:0]  fl_dq_i,           // Data out.
  output logic             ready_busy_output  // Ready.
);
  logic [7:0]  sr = 8'h80, d = 8'h00, pend = 8'h00, e;
  logic [4:0]  a = 5'h00;
  logic [31:0] lock = '0;
  logic        master = 1'b0;
  // A released bus shows inverted status, so a stale byte cannot pass for a read.
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? sr : ~sr;
  assign ready_busy_output = sr[7];
  // Sampling on the clock avoids racing the strobe against its own data.
  always @(posedge clk) if (!fl_we_n && !fl_ce_n) {a, d} = {fl_addr[20:16], fl_dq_o};
  // Supply, pin and lock flags are looked at only when a confirm starts the machine.
  always @(posedge fl_we_n) if (pend == 8'h60 || pend == 8'h20) begin
    sr[7] = 1'b0;
    if (d != 8'hD0 && (pend == 8'h20 || d != 8'h01 && d != 8'hF1)) e = 8'h30;
    else if (vpp_lo) e = (pend == 8'h60 && d != 8'hD0) ? 8'h18 : 8'h28;
    else if (pend == 8'h20) e = lock[a] && !fl_rp_override ? 8'h22 : 8'h00;
    else if (d == 8'h01) e = master && !fl_rp_override ? 8'h12 : 8'h00;
    else if (d == 8'hF1) e = fl_rp_override ? 8'h00 : 8'h12;
    else e = master && !fl_rp_override ? 8'h22 : 8'h00;
    if (e == 8'h00 && pend == 8'h60) begin
      if (d == 8'h01) lock[a] = 1'b1;
      if (d == 8'hF1) master = 1'b1;
      if (d == 8'hD0) lock = '0;
    end
    pend = 8'h00;
    repeat (BUSY) @(posedge clk);
    sr = {1'b1, sr[6:0] | e[6:0]};
  end else if (d == 8'h50) sr = 8'h80;
  else pend = d;
endmodule : flc_flash_model

// *** sim/flc_host_assertions.sv ***
`timescale 1ns/1ps
// Pin checks on writes, reads and the completion report.
module flc_host_assertions
  import flc_pkg::*;
(
  input wire logic       clk,         // Clock.
  input wire logic       srst,        // Reset.
  input wire logic       done,        // End pulse.
  input wire logic [7:0] done_status, // Final status.
  input wire logic       done_error,  // Error sum.
  input wire logic [7:0] fl_dq_o,     // Data out.
  input wire logic       fl_dq_oe,    // Drive enable.
  input wire logic       fl_ce_n,     // Chip enable.
  input wire logic       fl_we_n,     // Write strobe.
  input wire logic       fl_oe_n      // Read strobe.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wr_drive_a: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n && fl_oe_n)
    else $error("write without drive");
  rd_release_a: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("read while driving");
  cmd_code_a: assert property (!fl_we_n |->
    fl_dq_o inside {8'h60, 8'h01, 8'hF1, 8'hD0, 8'h20, 8'h50, 8'hFF}) else $error("bad code");
  lock_pair_a: assert property ($fell(fl_we_n) && fl_dq_o == 8'h60 |->
    ##[2:40] ($fell(fl_we_n) && fl_dq_o inside {8'h01, 8'hF1, 8'hD0})) else $error("no confirm");
  erase_pair_a: assert property ($fell(fl_we_n) && fl_dq_o == 8'h20 |->
    ##[2:40] ($fell(fl_we_n) && fl_dq_o == 8'hD0)) else $error("no erase confirm");
  rdy_status_a: assert property (done && done_status != 8'h00 |-> done_status[7])
    else $error("status taken busy");
  bit0_mask_a: assert property (done |-> !done_status[0])
    else $error("bit 0 unmasked");
  err_sum_a: assert property (done |-> done_error == |(done_status & SR_ERROR_MASK))
    else $error("error sum wrong");
  cover property (done && done_error);
  cover property (done && done_status == 8'h80);
  cover property ($fell(fl_we_n) && fl_dq_o == 8'hF1);
endmodule : flc_host_assertions
bind flc_host flc_host_assertions chk (.*);

// *** sim/flc_host_tb.sv ***
`timescale 1ns/1ps
// Orders lock, clear and erase operations and checks the status each one reports.
module flc_host_tb;
  import flc_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_override = 1'b0, vpp_lo = 1'b0;
  logic        cmd_ready, done, done_error, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_rp_n;
  logic        fl_rp_override, ready_busy_output;
  logic [7:0]  done_status, fl_dq_o, fl_dq_i;
  logic [20:0] cmd_addr = '0, fl_addr;
  flc_op_type  cmd_op = FLC_OP_READ_ARRAY;
  int          errors = 0, compares = 0;
  int          n_setup = 0, setup_base = 0;
  logic        we_prev = 1'b1;
  // Half period of 20 ns gives 25 MHz.
  always #20 clk = ~clk;
  flc_host dut (.*);
  flc_flash_model fm (.*);
  // Counts setup writes, so that the automatic repeat of an aborted clear can be seen.
  always @(posedge clk) begin
    if (!fl_we_n && we_prev && fl_dq_o == CMD_LOCK_SETUP) n_setup++;
    we_prev <= fl_we_n;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("BAD at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // One order; clr adds a status clear, since error flags stay until cleared.
  task automatic run(input flc_op_type op, input logic [4:0] blk, input logic ovr, vpp,
                     input logic [7:0] want, input logic clr = 1'b0);
    int n;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_op = op;
    cmd_addr = {blk, 16'h0000};
    cmd_override = ovr;
    vpp_lo = vpp;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    if (n == 3000) errors++;
    check(done_status, want);
    check({7'h00, done_error}, {7'h00, |(want & SR_ERROR_MASK)});
    @(negedge clk);
    check({7'h00, done}, 8'h00);
    check({7'h00, fl_rp_n}, 8'h01);
    $display("test %s done", op.name());
    if (clr) run(FLC_OP_CLEAR_STATUS, 5'h00, '0, '0, 8'h00);
  endtask : run
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // A hang is cut off well after the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    run(FLC_OP_SET_BLOCK, 5'h00, '0, '0, 8'h80);
    run(FLC_OP_ERASE, 5'h00, '0, '0, 8'hA2);
    run(FLC_OP_ERASE, 5'h01, '0, '0, 8'hA2, '1);
    run(FLC_OP_ERASE, 5'h00, '1, '0, 8'h80);
    setup_base = n_setup;
    run(FLC_OP_CLEAR_LOCKS, 5'h00, '0, '1, 8'hA8, '1);
    check(8'(n_setup - setup_base), 8'h02);
    run(FLC_OP_ERASE, 5'h00, '0, '0, 8'hA2, '1);
    run(FLC_OP_CLEAR_LOCKS, 5'h00, '0, '0, 8'h80);
    run(FLC_OP_SET_MASTER, 5'h00, '0, '0, 8'h92, '1);
    run(FLC_OP_SET_MASTER, 5'h00, '1, '0, 8'h80);
    run(FLC_OP_SET_BLOCK, 5'h01, '0, '0, 8'h92, '1);
    run(FLC_OP_SET_BLOCK, 5'h01, '1, '0, 8'h80);
    run(FLC_OP_CLEAR_LOCKS, 5'h00, '0, '0, 8'hA2, '1);
    run(FLC_OP_CLEAR_LOCKS, 5'h00, '1, '0, 8'h80);
    run(FLC_OP_ERASE, 5'h01, '0, '0, 8'h80);
    run(FLC_OP_CLEAR_LOCKS, 5'h00, '0, '0, 8'hA2, '1);
    run(FLC_OP_READ_ARRAY, 5'h00, '0, '0, 8'h00);
    tally_and_finish();
  end
endmodule : flc_host_tb
